// File: src/tfp_pkg.sv
// shared types and constants of the translation fault policy block
package tfp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int ADDR_W = 48;
  localparam int SYND_W = 16;
  localparam int APB_AW = 12;
  localparam int CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] REG_CAP = 12'h004;
  localparam logic [APB_AW-1:0] REG_STAT = 12'h008;

  // control fields
  localparam int CTRL_NSSD_BIT = 0;
  localparam int CTRL_RISKY_BIT = 1;
  // capability fields
  localparam int CAP_SEC_LSB = 0;
  localparam int CAP_NS_LSB = 4;
  localparam int CAP_TERM_BIT = 8;
  localparam int CAP_SECP_BIT = 12;
  // status fields
  localparam int STAT_REC_LSB = 0;
  localparam int STAT_DROP_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////
  // fault model capability codes
  localparam logic [1:0] CAP_BOTH = 2'h0;
  localparam logic [1:0] CAP_TERM = 2'h1;
  localparam logic [1:0] CAP_STALL = 2'h2;
  // termination model codes
  localparam logic TERM_BOTH = 1'h0;
  localparam logic TERM_ABORT_ONLY = 1'h1;

  ////////////////////////////////////////////////////////////////////////////
  // enumerations
  typedef enum logic [2:0] {
    FLT_XLATE,
    FLT_ADDR_SIZE,
    FLT_ACCESS_FLAG,
    FLT_PERM,
    FLT_WALK_ABORT,
    FLT_TLB_CONFLICT,
    FLT_CONFIG,
    FLT_UNSUPPORTED
  } tfp_fault_t;

  typedef enum logic [1:0] {
    ACT_ABORT,
    ACT_RAZWI,
    ACT_STALL,
    ACT_RETRY
  } tfp_action_t;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic is_write;
    logic is_instr;
    logic is_priv;
    logic is_nonsecure;
  } tfp_attr_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [SYND_W-1:0] syndrome;
    tfp_attr_t attr;
    tfp_fault_t ftype;
    logic stage2;
    logic ctx_stall_on_fault;
    logic ctx_abort_on_terminate;
    logic ctx_record_fault;
    logic stream_s2_stall_on_fault;
    logic stream_s2_record_fault;
    logic stream_s1_stall_disable;
    logic risky_client;
  } tfp_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [SYND_W-1:0] syndrome;
    tfp_attr_t attr;
    tfp_fault_t ftype;
    logic stage2;
    logic stall;
  } tfp_rec_t;

  typedef struct packed {
    tfp_action_t action;
    logic stage2;
  } tfp_resp_t;

  typedef struct packed {
    logic nssd;
    logic risky_en;
    logic resp_valid;
    tfp_resp_t resp;
    logic rec_valid;
    tfp_rec_t rec;
    logic sync_pend;
    logic sync_done;
    logic [CNT_W-1:0] rec_cnt;
    logic [CNT_W-1:0] drop_cnt;
    logic [31:0] prdata;
    logic pslverr;
  } tfp_state_t;

  typedef struct packed {
    logic [1:0] ns_cap;
  } tfp_cap_state_t;

  localparam tfp_state_t TFP_STATE_RST = '0;

  function automatic logic tfp_is_xlate(input tfp_fault_t f);
    tfp_is_xlate = (f == FLT_XLATE) || (f == FLT_ADDR_SIZE) ||
                   (f == FLT_ACCESS_FLAG) || (f == FLT_PERM);
  endfunction : tfp_is_xlate

endpackage : tfp_pkg

// File: src/tfp_stall_cap.sv
// non-secure stall capability derivation
`timescale 1ns/10ps
module tfp_stall_cap
  import tfp_pkg::*;
#(
  parameter logic [1:0] PHYS_STALL_MODEL = CAP_BOTH,
  parameter bit SECURE_PRESENT = 1'b1
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic nonsecure_stall_disable,
  // capability seen by non-secure software
  output logic [1:0] ns_stall_model
);

  tfp_cap_state_t s;
  tfp_cap_state_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.ns_cap = PHYS_STALL_MODEL;
    // filtering only makes sense when both models exist physically
    if (SECURE_PRESENT && PHYS_STALL_MODEL == CAP_BOTH && nonsecure_stall_disable)
    begin
      next_s.ns_cap = CAP_TERM;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s.ns_cap <= PHYS_STALL_MODEL;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign ns_stall_model = s.ns_cap;

  a_cap_filter: assert property (@(posedge clock) disable iff (rst)
    (SECURE_PRESENT && PHYS_STALL_MODEL == CAP_BOTH && nonsecure_stall_disable)
    |=> (ns_stall_model == CAP_TERM))
    else $error("non-secure capability not filtered to terminate only");

  a_cap_passthru: assert property (@(posedge clock) disable iff (rst)
    (!nonsecure_stall_disable || !SECURE_PRESENT) |=> (ns_stall_model == PHYS_STALL_MODEL))
    else $error("non-secure capability differs from physical");

endmodule : tfp_stall_cap

// File: src/tfp_fault_policy.sv
// translation fault policy: action decision, event recording, sync, APB registers
//
// Overview of operation
// - records come only from faults reported to this block, never downstream aborts.
// - response and event record are not ordered against each other.
// - sync completes only after all owed event records were handed over.
// - each fault is decided from its own request, the risky enable and queue full; no per-stream state.
// - stage-1 fault, stall clear, abort set: terminate with abort.
// - stage-1 fault, stall and abort clear: complete, reads zero, writes dropped.
// - stage-1 fault with stall set stalls unless stream stall-disable forbids it.
// - stage-2 fault aborts when stream stall bit clear, stalls when set.
// - with secure side, secure field physical, non-secure field filtered.
// - both plus disable gives terminate-only; other capabilities pass unchanged.
// - without secure side the non-secure field shows physical capability.
// - terminated stage-2 faults always get an abort, never zero completion.
// - risky clients may turn stall into abort, record with stall flag 0.
// - record bit set on terminating stage writes one full event record.
// - queue full at record time: record dropped, transaction not held.
// - default capability and termination model both report zero.
// - only four fault types follow the configurable policy.
// - all other faults and configuration errors always abort.
// - stream stage-1 stall-disable prevents stage-1 stall regardless of context.
`timescale 1ns/10ps
module tfp_fault_policy
  import tfp_pkg::*;
#(
  parameter logic [1:0] PHYS_STALL_MODEL = CAP_BOTH,
  parameter logic TERM_MODEL = TERM_BOTH,
  parameter bit SECURE_PRESENT = 1'b1
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // faulting transaction in
  input wire logic fault_valid,
  input wire tfp_req_t fault_req,
  output logic fault_ready,
  // response toward the client
  output logic resp_valid,
  output tfp_resp_t resp,
  // event queue writer
  output logic evt_valid,
  output tfp_rec_t evt_rec,
  input wire logic evt_ready,
  input wire logic evq_full,
  // synchronisation
  input wire logic sync_req,
  output logic sync_done,
  // capability outputs
  output logic [1:0] sec_stall_model,
  output logic [1:0] ns_stall_model
);

  tfp_state_t s;
  tfp_state_t next_s;
  logic take;
  logic apb_setup;
  logic apb_write;
  logic [1:0] ns_cap;

  ////////////////////////////////////////////////////////////////////////////
  // capability derivation

  tfp_stall_cap #(
    .PHYS_STALL_MODEL(PHYS_STALL_MODEL),
    .SECURE_PRESENT(SECURE_PRESENT)
  ) u_cap (
    .clock(clock),
    .rst(rst),
    .nonsecure_stall_disable(s.nssd),
    .ns_stall_model(ns_cap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // handshakes

  // a held record must leave before the next fault can be decided
  assign fault_ready = !s.rec_valid || evt_ready;
  assign take = fault_valid && fault_ready;
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    tfp_action_t act;
    logic want_rec;
    logic stall_ok;
    logic [31:0] rd;
    act = ACT_ABORT;
    want_rec = 1'b1;
    stall_ok = (PHYS_STALL_MODEL != CAP_TERM);
    rd = '0;
    next_s = s;

    // decision depends on this request, risky enable and queue full; nothing per stream is kept
    if (!tfp_is_xlate(fault_req.ftype))
    begin
      act = ACT_ABORT;
      want_rec = 1'b1;
    end
    else if (fault_req.stage2)
    begin
      if (fault_req.stream_s2_stall_on_fault && stall_ok)
      begin
        act = ACT_STALL;
      end
      else
      begin
        act = ACT_ABORT;
      end
      want_rec = (act == ACT_STALL) || fault_req.stream_s2_record_fault;
    end
    else
    begin
      if (fault_req.ctx_stall_on_fault && !fault_req.stream_s1_stall_disable && stall_ok)
      begin
        act = ACT_STALL;
      end
      else if (fault_req.ctx_abort_on_terminate || TERM_MODEL == TERM_ABORT_ONLY)
      begin
        // abort-only parts cannot honour a zero completion anyway
        act = ACT_ABORT;
      end
      else
      begin
        act = ACT_RAZWI;
      end
      want_rec = (act == ACT_STALL) || fault_req.ctx_record_fault;
    end

    // risky clients: stall configuration treated as terminate
    if (act == ACT_STALL && fault_req.risky_client && s.risky_en &&
        PHYS_STALL_MODEL == CAP_BOTH)
    begin
      act = ACT_ABORT;
      want_rec = 1'b1;
    end

    // a stall that cannot be recorded is handed back for a later retry
    if (act == ACT_STALL && evq_full)
    begin
      act = ACT_RETRY;
    end

    // event hand-over
    if (s.rec_valid && evt_ready)
    begin
      next_s.rec_valid = 1'b0;
      next_s.rec_cnt = s.rec_cnt + 1'b1;
    end

    // response goes out regardless of the record's fate
    next_s.resp_valid = take;
    if (take)
    begin
      next_s.resp.action = act;
      next_s.resp.stage2 = fault_req.stage2;
      if (want_rec && act != ACT_RETRY)
      begin
        if (evq_full)
        begin
          next_s.drop_cnt = s.drop_cnt + 1'b1;
        end
        else
        begin
          // only faults presented here are recorded
          next_s.rec_valid = 1'b1;
          next_s.rec.addr = fault_req.addr;
          next_s.rec.syndrome = fault_req.syndrome;
          next_s.rec.attr = fault_req.attr;
          next_s.rec.ftype = fault_req.ftype;
          next_s.rec.stage2 = fault_req.stage2;
          next_s.rec.stall = (act == ACT_STALL);
        end
      end
    end

    // sync waits for the holding register to drain
    next_s.sync_done = 1'b0;
    if (s.sync_pend && !s.rec_valid)
    begin
      next_s.sync_done = 1'b1;
      next_s.sync_pend = 1'b0;
    end
    if (sync_req)
    begin
      next_s.sync_pend = 1'b1;
    end

    // apb: read data captured in setup so it is a flop in access
    if (apb_setup)
    begin
      next_s.pslverr = 1'b0;
      case (paddr)
        REG_CTRL:
        begin
          rd[CTRL_NSSD_BIT] = s.nssd;
          rd[CTRL_RISKY_BIT] = s.risky_en;
        end
        REG_CAP:
        begin
          rd[CAP_SEC_LSB +: 2] = PHYS_STALL_MODEL;
          rd[CAP_NS_LSB +: 2] = ns_cap;
          rd[CAP_TERM_BIT] = TERM_MODEL;
          rd[CAP_SECP_BIT] = SECURE_PRESENT;
        end
        REG_STAT:
        begin
          rd[STAT_REC_LSB +: CNT_W] = s.rec_cnt;
          rd[STAT_DROP_LSB +: CNT_W] = s.drop_cnt;
        end
        default:
        begin
          next_s.pslverr = 1'b1;
        end
      endcase
      next_s.prdata = pwrite ? '0 : rd;
    end
    if (apb_write && paddr == REG_CTRL)
    begin
      next_s.nssd = pwdata[CTRL_NSSD_BIT];
      next_s.risky_en = pwdata[CTRL_RISKY_BIT];
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s <= TFP_STATE_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign resp_valid = s.resp_valid;
  assign resp = s.resp;
  assign evt_valid = s.rec_valid;
  assign evt_rec = s.rec;
  assign sync_done = s.sync_done;
  assign sec_stall_model = PHYS_STALL_MODEL;
  assign ns_stall_model = ns_cap;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_s1_abort: assert property (@(posedge clock) disable iff (rst)
    (take && tfp_is_xlate(fault_req.ftype) && !fault_req.stage2 &&
     !fault_req.ctx_stall_on_fault && fault_req.ctx_abort_on_terminate)
    |=> (resp_valid && resp.action == ACT_ABORT))
    else $error("stage-1 abort configuration not aborted");

  a_s1_razwi: assert property (@(posedge clock) disable iff (rst)
    (take && tfp_is_xlate(fault_req.ftype) && !fault_req.stage2 &&
     !fault_req.ctx_stall_on_fault && !fault_req.ctx_abort_on_terminate &&
     TERM_MODEL == TERM_BOTH)
    |=> (resp_valid && resp.action == ACT_RAZWI))
    else $error("stage-1 zero completion not taken");

  a_s1_stall_off: assert property (@(posedge clock) disable iff (rst)
    (take && !fault_req.stage2 && fault_req.stream_s1_stall_disable)
    |=> (resp.action != ACT_STALL && !(evt_valid && evt_rec.stall && !$past(evt_valid))))
    else $error("stage-1 stall despite stream stall disable");

  a_s2_abort: assert property (@(posedge clock) disable iff (rst)
    (take && fault_req.stage2 && !fault_req.stream_s2_stall_on_fault)
    |=> (resp_valid && resp.action == ACT_ABORT))
    else $error("terminated stage-2 fault not aborted");

  a_other_abort: assert property (@(posedge clock) disable iff (rst)
    (take && !tfp_is_xlate(fault_req.ftype)) |=> (resp.action == ACT_ABORT))
    else $error("non-translation fault not aborted");

  a_sync_order: assert property (@(posedge clock) disable iff (rst)
    $rose(sync_done) |-> ($past(s.sync_pend) && !$past(evt_valid)))
    else $error("sync completed with a record still owed");

  a_full_drop: assert property (@(posedge clock) disable iff (rst)
    (take && evq_full) |=> (resp_valid && !evt_valid))
    else $error("record not dropped or transaction held on full queue");

  a_rec_write: assert property (@(posedge clock) disable iff (rst)
    (take && !evq_full && fault_req.stage2 && fault_req.stream_s2_record_fault)
    |=> (evt_valid && evt_rec.addr == $past(fault_req.addr) && evt_rec.stage2))
    else $error("stage-2 record not written");

  a_no_record: assert property (@(posedge clock) disable iff (rst)
    (take && tfp_is_xlate(fault_req.ftype) && !fault_req.stage2 &&
     !fault_req.ctx_stall_on_fault && !fault_req.ctx_record_fault)
    |=> !evt_valid)
    else $error("record written with record bit clear");

  a_s1_stall: assert property (@(posedge clock) disable iff (rst)
    (take && tfp_is_xlate(fault_req.ftype) && !fault_req.stage2 &&
     fault_req.ctx_stall_on_fault && !fault_req.stream_s1_stall_disable &&
     !fault_req.risky_client && !evq_full && PHYS_STALL_MODEL != CAP_TERM)
    |=> (resp_valid && resp.action == ACT_STALL && evt_valid && evt_rec.stall))
    else $error("stage-1 stall configuration not stalled");

  a_s2_stall: assert property (@(posedge clock) disable iff (rst)
    (take && tfp_is_xlate(fault_req.ftype) && fault_req.stage2 &&
     fault_req.stream_s2_stall_on_fault && !fault_req.risky_client && !evq_full &&
     PHYS_STALL_MODEL != CAP_TERM)
    |=> (resp_valid && resp.action == ACT_STALL && evt_valid && evt_rec.stall))
    else $error("stage-2 stall configuration not stalled");

  a_risky_term: assert property (@(posedge clock) disable iff (rst)
    (take && tfp_is_xlate(fault_req.ftype) && fault_req.risky_client && s.risky_en &&
     !evq_full && PHYS_STALL_MODEL == CAP_BOTH &&
     (fault_req.stage2 ? fault_req.stream_s2_stall_on_fault :
      (fault_req.ctx_stall_on_fault && !fault_req.stream_s1_stall_disable)))
    |=> (resp.action == ACT_ABORT && evt_valid && !evt_rec.stall))
    else $error("risky client stall not turned into recorded abort");

  a_rec_fields: assert property (@(posedge clock) disable iff (rst)
    (take && !evq_full && tfp_is_xlate(fault_req.ftype) && !fault_req.stage2 &&
     !fault_req.ctx_stall_on_fault && fault_req.ctx_record_fault)
    |=> (evt_valid && evt_rec.syndrome == $past(fault_req.syndrome) &&
         evt_rec.attr == $past(fault_req.attr) && evt_rec.ftype == $past(fault_req.ftype) &&
         !evt_rec.stage2 && !evt_rec.stall))
    else $error("stage-1 record fields not written");

  a_sync_wait: assert property (@(posedge clock) disable iff (rst)
    (s.sync_pend && evt_valid) |=> !sync_done)
    else $error("sync completed while a record was held");

  a_resp_once: assert property (@(posedge clock) disable iff (rst)
    resp_valid |-> $past(take))
    else $error("response without a taken fault");

endmodule : tfp_fault_policy

// File: verif/tfp_evq_model.sv
// event queue consumer model facing the record port of the fault policy block
`timescale 1ns/10ps
module tfp_evq_model
  import tfp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bench controls
  input wire logic stall,
  input wire logic full,
  // record stream
  input wire logic evt_valid,
  input wire tfp_rec_t evt_rec,
  output logic evt_ready,
  output logic evq_full,
  output int taken
);
  ////////////////////////////////////////////////////////////////////////////
  // stall holds a record in the block, so sync and back-pressure get exercised
  assign evt_ready = !stall;
  assign evq_full = full;
  always_ff @(posedge clock)
  begin
    if (rst)
      taken <= 0;
    else if (evt_valid && evt_ready)
      taken <= taken + 1;
  end
endmodule : tfp_evq_model

// File: verif/tfp_fault_policy_bench.sv
// self-checking bench of the translation fault policy block
`timescale 1ns/10ps
module tfp_fault_policy_bench;
  import tfp_pkg::*;
  logic clock, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, prdata2, rd;
  logic fault_valid, fault_ready, resp_valid, evt_valid, evt_ready, evq_full;
  logic sync_req, sync_done, q_stall, q_full;
  logic [1:0] sec_stall_model, ns_stall_model, ns2;
  tfp_req_t fault_req;
  tfp_resp_t resp;
  tfp_rec_t evt_rec;
  int fails, num_checks, n_rec, n_done, n_taken;

  tfp_fault_policy u_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_valid(fault_valid), .fault_req(fault_req),
    .fault_ready(fault_ready), .resp_valid(resp_valid), .resp(resp),
    .evt_valid(evt_valid), .evt_rec(evt_rec), .evt_ready(evt_ready), .evq_full(evq_full),
    .sync_req(sync_req), .sync_done(sync_done), .sec_stall_model(sec_stall_model),
    .ns_stall_model(ns_stall_model));
  // stall-only, abort-only part without secure side: no filtering possible
  tfp_fault_policy #(.PHYS_STALL_MODEL(CAP_STALL), .TERM_MODEL(TERM_ABORT_ONLY),
    .SECURE_PRESENT(1'b0)) u_dut_nosec (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata2),
    .pready(), .pslverr(), .fault_valid(fault_valid), .fault_req(fault_req),
    .fault_ready(), .resp_valid(), .resp(), .evt_valid(), .evt_rec(), .evt_ready(evt_ready),
    .evq_full(evq_full), .sync_req(sync_req), .sync_done(), .sec_stall_model(),
    .ns_stall_model(ns2));
  tfp_evq_model u_evq (.clock(clock), .rst(rst), .stall(q_stall), .full(q_full),
    .evt_valid(evt_valid), .evt_rec(evt_rec), .evt_ready(evt_ready), .evq_full(evq_full),
    .taken(n_taken));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (fails == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // flags: stage2, ctx stall, ctx abort, ctx record, s2 stall, s2 record, s1 disable, risky
  function automatic tfp_req_t mk(input tfp_fault_t ft, input logic [7:0] f);
    tfp_req_t q;
    q = '0;
    q.addr = {32'h0000_1234, f, 8'h40};
    q.syndrome = 16'h00A5;
    q.attr = 4'h5;
    q.ftype = ft;
    {q.stage2, q.ctx_stall_on_fault, q.ctx_abort_on_terminate, q.ctx_record_fault,
     q.stream_s2_stall_on_fault, q.stream_s2_record_fault, q.stream_s1_stall_disable,
     q.risky_client} = f;
    return q;
  endfunction : mk

  task automatic flt(input tfp_req_t q, input tfp_action_t act, input logic rec);
    @(posedge clock);
    fault_req <= q;
    fault_valid <= 1'b1;
    @(negedge clock);
    while (fault_ready !== 1'b1)
    begin
      @(negedge clock);
    end
    @(posedge clock);
    fault_valid <= 1'b0;
    @(negedge clock);
    chk("resp_valid", 1, resp_valid);
    chk("action", act, resp.action);
    chk("stage2", q.stage2, resp.stage2);
    chk("evt_valid", rec, evt_valid);
    if (rec)
    begin
      chk("evt_addr", q.addr[31:0], evt_rec.addr[31:0]);
      chk("evt_synd", q.syndrome, evt_rec.syndrome);
      chk("evt_type", {q.attr, q.ftype, q.stage2},
        {evt_rec.attr, evt_rec.ftype, evt_rec.stage2});
      chk("evt_stall", act == ACT_STALL, evt_rec.stall);
      n_rec++;
    end
  endtask : flt

  task automatic cnt_done(input int cyc);
    n_done = 0;
    repeat (cyc)
    begin
      @(negedge clock);
      if (sync_done === 1'b1)
        n_done++;
    end
  endtask : cnt_done

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial
  begin
    repeat (5000) @(posedge clock);
    fails++;
    test_done();
  end

  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata} = '0;
    {fault_valid, sync_req, q_stall, q_full} = '0;
    fault_req = '0;
    rst = 1'b1;
    {fails, num_checks, n_rec} = '0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    apb(1'b0, REG_CAP, 32'h0);
    chk("cap_reset", 32'h0000_1000, rd);
    chk("sec_cap", CAP_BOTH, sec_stall_model);
    chk("cap_nosec", 32'h0000_0122, prdata2);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped_err", 1, err);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    apb(1'b0, REG_CAP, 32'h0);
    chk("cap_nssd", 32'h0000_1010, rd);
    chk("ns_cap", CAP_TERM, ns_stall_model);
    chk("ns_cap_nofilter", CAP_STALL, ns2);
    // stage-1 and stage-2 policy table
    flt(mk(FLT_XLATE, 8'h30), ACT_ABORT, 1'b1);
    flt(mk(FLT_PERM, 8'h00), ACT_RAZWI, 1'b0);
    flt(mk(FLT_XLATE, 8'h40), ACT_STALL, 1'b1);
    flt(mk(FLT_ACCESS_FLAG, 8'h62), ACT_ABORT, 1'b0);
    flt(mk(FLT_PERM, 8'h72), ACT_ABORT, 1'b1);
    flt(mk(FLT_XLATE, 8'h84), ACT_ABORT, 1'b1);
    flt(mk(FLT_ADDR_SIZE, 8'h88), ACT_STALL, 1'b1);
    flt(mk(FLT_XLATE, 8'hC0), ACT_ABORT, 1'b0);
    flt(mk(FLT_XLATE, 8'h41), ACT_STALL, 1'b1);
    for (int i = 0; i < 8; i++)
      flt(mk(tfp_fault_t'(i), 8'h00), i < 4 ? ACT_RAZWI : ACT_ABORT, i >= 4);
    // risky clients turned to terminate
    apb(1'b1, REG_CTRL, 32'h0000_0002);
    apb(1'b0, REG_CAP, 32'h0);
    chk("cap_clear", 32'h0000_1000, rd);
    flt(mk(FLT_PERM, 8'h41), ACT_ABORT, 1'b1);
    // full queue drops the record but still answers
    @(posedge clock);
    q_full <= 1'b1;
    flt(mk(FLT_XLATE, 8'h30), ACT_ABORT, 1'b0);
    flt(mk(FLT_XLATE, 8'h40), ACT_RETRY, 1'b0);
    @(posedge clock);
    q_full <= 1'b0;
    apb(1'b0, REG_STAT, 32'h0);
    chk("stat", {16'h0001, n_rec[15:0]}, rd);
    // sync waits for a held record
    @(posedge clock);
    q_stall <= 1'b1;
    flt(mk(FLT_XLATE, 8'h30), ACT_ABORT, 1'b1);
    @(posedge clock);
    sync_req <= 1'b1;
    @(posedge clock);
    sync_req <= 1'b0;
    cnt_done(6);
    chk("sync_early", 0, n_done);
    chk("held_ready", 0, fault_ready);
    @(posedge clock);
    q_stall <= 1'b0;
    cnt_done(6);
    chk("sync_done", 1, n_done);
    chk("taken", n_rec, n_taken);
    test_done();
  end
endmodule : tfp_fault_policy_bench
